// ### rtl/cmdf_pkg.sv
// Purpose: constants and types of the command admission filter
// Assumes: 8-bit register address, 32-bit register data
// Notes: opcode, log page and fabrics type values are the usual encodings
package cmdf_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   // register offsets
   localparam logic [7:0] REG_CTRL_OFS = 8'h00;
   localparam logic [7:0] REG_STATUS_OFS = 8'h04;
   localparam logic [7:0] REG_ABORTS_OFS = 8'h08;
   // control register fields and reset value
   localparam int CTRL_DIR_SUP_BIT = 0;
   localparam int CTRL_STR_SUP_BIT = 1;
   localparam int CTRL_STR_EN_BIT = 2;
   localparam logic [2:0] CTRL_RST = 3'h0;
   // status register fields
   localparam int STAT_SAN_LSB = 0;
   localparam int STAT_LAST_LSB = 4;
   localparam int STAT_UNRES_BIT = 8;
   // optional admin support field: directives bit
   localparam int OPTIONAL_ADMIN_SUPPORT_FIELD_W = 16;
   localparam int OPTIONAL_ADMIN_SUPPORT_FIELD_DIR_BIT = 5;
   // admin opcodes
   localparam logic [7:0] OPC_DEL_SQ = 8'h00;
   localparam logic [7:0] OPC_CRE_SQ = 8'h01;
   localparam logic [7:0] OPC_GET_LOG = 8'h02;
   localparam logic [7:0] OPC_DEL_CQ = 8'h04;
   localparam logic [7:0] OPC_CRE_CQ = 8'h05;
   localparam logic [7:0] OPC_IDENTIFY = 8'h06;
   localparam logic [7:0] OPC_ABORT = 8'h08;
   localparam logic [7:0] OPC_SET_FEAT = 8'h09;
   localparam logic [7:0] OPC_GET_FEAT = 8'h0a;
   localparam logic [7:0] OPC_ASYNC_EVT = 8'h0c;
   localparam logic [7:0] OPC_KEEP_ALIVE = 8'h18;
   localparam logic [7:0] OPC_DIR_SEND = 8'h19;
   localparam logic [7:0] OPC_DIR_RECV = 8'h1a;
   localparam logic [7:0] OPC_MI_SEND = 8'h1d;
   localparam logic [7:0] OPC_MI_RECV = 8'h1e;
   localparam logic [7:0] OPC_FABRICS = 8'h7f;
   localparam logic [7:0] OPC_SANITIZE = 8'h84;
   localparam logic [7:0] OPC_VENDOR_MIN = 8'hc0;
   // io opcodes
   localparam logic [7:0] OPC_IO_WRITE = 8'h01;
   // log page identifiers
   localparam logic [7:0] LID_ERROR = 8'h01;
   localparam logic [7:0] LID_SMART = 8'h02;
   localparam logic [7:0] LID_CHG_NS = 8'h04;
   localparam logic [7:0] LID_RESV = 8'h80;
   localparam logic [7:0] LID_SANITIZE = 8'h81;
   // fabrics command types
   localparam logic [7:0] FCT_PROP_SET = 8'h00;
   localparam logic [7:0] FCT_CONNECT = 8'h01;
   localparam logic [7:0] FCT_PROP_GET = 8'h04;
   localparam logic [7:0] FCT_AUTH_SEND = 8'h05;
   localparam logic [7:0] FCT_AUTH_RECV = 8'h06;
   localparam logic [7:0] FCT_VENDOR_MIN = 8'hc0;
   // sanitize actions
   localparam logic [2:0] SACT_EXIT_FAIL = 3'h1;
   localparam logic [2:0] SACT_BLOCK = 3'h2;
   localparam logic [2:0] SACT_OVERWRITE = 3'h3;
   localparam logic [2:0] SACT_CRYPTO = 3'h4;
   // directive types
   localparam logic [7:0] DIRECTIVE_TYPE_FIELD_IDENTIFY = 8'h00;
   localparam logic [7:0] DIRECTIVE_TYPE_FIELD_STREAMS = 8'h01;
   localparam logic [7:0] DIRECTIVE_TYPE_FIELD_IO_MASK = 8'h0f;
   localparam logic [15:0] DIRECTIVE_SPECIFIC_FIELD_NONE = 16'h0000;
   // completion status codes
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_SAN_PROG = 2'h1;
   localparam logic [1:0] ST_SAN_FAIL = 2'h2;
   localparam logic [1:0] ST_INV_FIELD = 2'h3;
   // subsystem sanitize state
   typedef enum logic [2:0] {
      SAN_IDLE = 3'b001,
      SAN_PROG = 3'b010,
      SAN_FAIL = 3'b100
   } cmdf_san_t;
   // whole state of the filter
   typedef struct packed {
      cmdf_san_t san;
      logic [2:0] ctrl;
      logic [15:0] aborts;
      logic [1:0] last_status;
      logic rsp_valid;
      logic rsp_abort;
      logic [1:0] rsp_status;
      logic rsp_str_valid;
      logic [15:0] rsp_str_id;
      logic rsp_zero_lba;
      logic [15:0] rsp_cid;
      logic [31:0] rd_data;
   } cmdf_state_t;
endpackage : cmdf_pkg

// ### rtl/cmdf_filter.sv
// Purpose: admit or abort each fetched command by sanitize and directive
// Assumes: one command per cycle at most, fields valid with cmd_valid_i
// Notes: verdict appears one cycle after the command, as a pulse
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps

// Overview of operation
// - during sanitize only listed admin commands pass
// - io commands abort with sanitize in progress
// - unlisted commands abort with sanitize in progress
// - failed state aborts io with sanitize failed
// - failed state aborts unlisted, non-sanitize commands
// - failed state accepts sanitize with restricted actions
// - plain admin list passes without extra checks
// - get log page limited to five pages
// - error log lba field returned as zero
// - management send/receive only when explicitly permitted
// - fabrics set, get, connect, authentication pass
// - vendor commands pass only without user data
// - advertise directives, support send, receive, identify
// - type 00h identify, type 01h streams
// - unsupported or disabled directive type aborts invalid
// - io directive type uses low four bits
// - io directive type zero means no directive
// - only write interprets directive fields
// - directive specific holds stream id for streams
// - no io directive enabled means fields ignored
// - enabled but unsupported io type aborts invalid
// - streams with zero specific is plain write
// - failed state left by a new sanitize start or exit action
module cmdf_filter (
   input wire logic sys_clk_i,
   input wire logic srst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   // sanitize engine events and levels
   input wire logic san_start_i,
   input wire logic san_pass_i,
   input wire logic san_fail_i,
   input wire logic san_exit_i,
   input wire logic san_unres_exit_i,
   input wire logic mi_permit_i,
   // fetched command
   input wire logic cmd_valid_i,
   input wire logic cmd_is_io_i,
   input wire logic [15:0] cmd_cid_i,
   input wire logic [7:0] cmd_opcode_i,
   input wire logic [7:0] cmd_log_id_i,
   input wire logic [7:0] cmd_fctype_i,
   input wire logic [2:0] cmd_san_act_i,
   input wire logic cmd_user_data_i,
   input wire logic [7:0] directive_type_field_i,
   input wire logic [15:0] directive_specific_field_i,
   // verdict
   output logic rsp_valid_o,
   output logic rsp_abort_o,
   output logic [1:0] rsp_status_o,
   output logic [15:0] rsp_cid_o,
   output logic rsp_stream_valid_o,
   output logic [15:0] rsp_stream_id_o,
   output logic rsp_zero_lba_o,
   output logic [15:0] optional_admin_support_field_o,
   output logic [2:0] san_state_o
);

   cmdf_pkg::cmdf_state_t st_reg;
   cmdf_pkg::cmdf_state_t st_next;

   logic restricted;
   logic [1:0] rstat;
   logic list_ok;
   logic dir_sup;
   logic str_ok;
   logic [7:0] io_directive_type_field;
   logic abort;
   logic [1:0] status;
   logic str_valid;
   logic zero_lba;

   // admin commands that pass a restricted state unconditionally
   function automatic logic is_plain_admin(input logic [7:0] op);
      is_plain_admin = (op == cmdf_pkg::OPC_ABORT) ||
         (op == cmdf_pkg::OPC_ASYNC_EVT) ||
         (op == cmdf_pkg::OPC_CRE_CQ) || (op == cmdf_pkg::OPC_CRE_SQ) ||
         (op == cmdf_pkg::OPC_DEL_CQ) || (op == cmdf_pkg::OPC_DEL_SQ) ||
         (op == cmdf_pkg::OPC_GET_FEAT) || (op == cmdf_pkg::OPC_SET_FEAT) ||
         (op == cmdf_pkg::OPC_IDENTIFY) || (op == cmdf_pkg::OPC_KEEP_ALIVE);
   endfunction : is_plain_admin

   // log pages readable in a restricted state
   function automatic logic is_log_ok(input logic [7:0] lid);
      is_log_ok = (lid == cmdf_pkg::LID_ERROR) ||
         (lid == cmdf_pkg::LID_SMART) || (lid == cmdf_pkg::LID_CHG_NS) ||
         (lid == cmdf_pkg::LID_RESV) || (lid == cmdf_pkg::LID_SANITIZE);
   endfunction : is_log_ok

   // fabrics command types allowed in a restricted state
   function automatic logic is_fab_ok(input logic [7:0] fct,
                                      input logic udata);
      is_fab_ok = (fct == cmdf_pkg::FCT_PROP_SET) ||
         (fct == cmdf_pkg::FCT_PROP_GET) || (fct == cmdf_pkg::FCT_CONNECT) ||
         (fct == cmdf_pkg::FCT_AUTH_SEND) ||
         (fct == cmdf_pkg::FCT_AUTH_RECV) ||
         ((fct >= cmdf_pkg::FCT_VENDOR_MIN) && !udata);
   endfunction : is_fab_ok

   // sanitize actions accepted while in the failed state
   function automatic logic is_act_ok(input logic [2:0] act,
                                      input logic unres);
      is_act_ok = ((act == cmdf_pkg::SACT_EXIT_FAIL) && unres) ||
         (act == cmdf_pkg::SACT_BLOCK) ||
         (act == cmdf_pkg::SACT_OVERWRITE) ||
         (act == cmdf_pkg::SACT_CRYPTO);
   endfunction : is_act_ok

   // restricted-state admission and its abort status
   assign restricted = (st_reg.san != cmdf_pkg::SAN_IDLE);
   assign rstat = (st_reg.san == cmdf_pkg::SAN_PROG) ?
                  cmdf_pkg::ST_SAN_PROG : cmdf_pkg::ST_SAN_FAIL;
   assign dir_sup = st_reg.ctrl[cmdf_pkg::CTRL_DIR_SUP_BIT];
   // streams usable only if supported and enabled
   assign str_ok = dir_sup && st_reg.ctrl[cmdf_pkg::CTRL_STR_SUP_BIT] &&
                   st_reg.ctrl[cmdf_pkg::CTRL_STR_EN_BIT];
   // upper four type bits taken as zero
   assign io_directive_type_field = directive_type_field_i & cmdf_pkg::DIRECTIVE_TYPE_FIELD_IO_MASK;

   // permitted list for restricted states
   always_comb begin
      list_ok = 1'b0;
      if (!cmd_is_io_i) begin
         if (is_plain_admin(cmd_opcode_i)) begin
            list_ok = 1'b1;
         end else if (cmd_opcode_i == cmdf_pkg::OPC_GET_LOG) begin
            list_ok = is_log_ok(cmd_log_id_i);
         end else if ((cmd_opcode_i == cmdf_pkg::OPC_MI_SEND) ||
                      (cmd_opcode_i == cmdf_pkg::OPC_MI_RECV)) begin
            list_ok = mi_permit_i;
         end else if (cmd_opcode_i == cmdf_pkg::OPC_FABRICS) begin
            list_ok = is_fab_ok(cmd_fctype_i, cmd_user_data_i);
         end else if (cmd_opcode_i >= cmdf_pkg::OPC_VENDOR_MIN) begin
            list_ok = !cmd_user_data_i;
         end else if ((cmd_opcode_i == cmdf_pkg::OPC_SANITIZE) &&
                      (st_reg.san == cmdf_pkg::SAN_FAIL)) begin
            list_ok = is_act_ok(cmd_san_act_i, san_unres_exit_i);
         end
      end
   end

   // verdict: sanitize gating first, then directive fields
   always_comb begin
      abort = 1'b0;
      status = cmdf_pkg::ST_OK;
      str_valid = 1'b0;
      zero_lba = 1'b0;
      if (restricted) begin
         // io aborted with the in-progress status
         // io aborted with the failed status
         if (cmd_is_io_i || !list_ok) begin
            abort = 1'b1;
            status = rstat;
         end else if (cmd_opcode_i == cmdf_pkg::OPC_GET_LOG) begin
            zero_lba = (cmd_log_id_i == cmdf_pkg::LID_ERROR);
         end
      end else if (!cmd_is_io_i) begin
         if ((cmd_opcode_i == cmdf_pkg::OPC_DIR_SEND) ||
             (cmd_opcode_i == cmdf_pkg::OPC_DIR_RECV)) begin
            if (!dir_sup) begin
               abort = 1'b1;
               status = cmdf_pkg::ST_INV_FIELD;
            end else if (directive_type_field_i ==
                         cmdf_pkg::DIRECTIVE_TYPE_FIELD_IDENTIFY) begin
               abort = 1'b0;
            end else if (!((directive_type_field_i ==
                            cmdf_pkg::DIRECTIVE_TYPE_FIELD_STREAMS) && str_ok)) begin
               abort = 1'b1;
               status = cmdf_pkg::ST_INV_FIELD;
            end
         end
      end else if (cmd_opcode_i == cmdf_pkg::OPC_IO_WRITE) begin
         // only write looks at directive fields
         if (!str_ok || (io_directive_type_field == cmdf_pkg::DIRECTIVE_TYPE_FIELD_IDENTIFY)) begin
            str_valid = 1'b0;
         end else if (io_directive_type_field == cmdf_pkg::DIRECTIVE_TYPE_FIELD_STREAMS) begin
            // specific field is the stream id
            // zero stream id is a plain write
            str_valid = (directive_specific_field_i != cmdf_pkg::DIRECTIVE_SPECIFIC_FIELD_NONE);
         end else begin
            abort = 1'b1;
            status = cmdf_pkg::ST_INV_FIELD;
         end
      end
   end

   // next state: sanitize tracking, registers, verdict capture
   always_comb begin
      st_next = st_reg;
      // leave failed state on a new start or exit
      case (st_reg.san)
         cmdf_pkg::SAN_IDLE: begin
            if (san_start_i) begin
               st_next.san = cmdf_pkg::SAN_PROG;
            end
         end
         cmdf_pkg::SAN_PROG: begin
            if (san_fail_i) begin
               st_next.san = cmdf_pkg::SAN_FAIL;
            end else if (san_pass_i) begin
               st_next.san = cmdf_pkg::SAN_IDLE;
            end
         end
         cmdf_pkg::SAN_FAIL: begin
            if (san_start_i) begin
               st_next.san = cmdf_pkg::SAN_PROG;
            end else if (san_exit_i) begin
               st_next.san = cmdf_pkg::SAN_IDLE;
            end
         end
         default: begin
            st_next.san = cmdf_pkg::SAN_IDLE;
         end
      endcase
      // verdict pulse with its data
      st_next.rsp_valid = cmd_valid_i;
      if (cmd_valid_i) begin
         st_next.rsp_abort = abort;
         st_next.rsp_status = status;
         st_next.rsp_cid = cmd_cid_i;
         st_next.rsp_str_valid = str_valid;
         st_next.rsp_str_id = str_valid ? directive_specific_field_i :
                              16'h0000;
         st_next.rsp_zero_lba = zero_lba;
         st_next.last_status = status;
      end
      // control register write
      if (reg_wr_i && (reg_addr_i == cmdf_pkg::REG_CTRL_OFS)) begin
         st_next.ctrl = reg_wdata_i[2:0];
      end
      // abort counter: a count in the clearing cycle survives
      if (reg_wr_i && (reg_addr_i == cmdf_pkg::REG_ABORTS_OFS)) begin
         st_next.aborts = 16'h0000;
      end
      if (cmd_valid_i && abort && (st_next.aborts != 16'hffff)) begin
         st_next.aborts = st_next.aborts + 16'h0001;
      end
      // read data stands only in the cycle after the strobe
      st_next.rd_data = 32'h0000_0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            cmdf_pkg::REG_CTRL_OFS: begin
               st_next.rd_data[2:0] = st_reg.ctrl;
            end
            cmdf_pkg::REG_STATUS_OFS: begin
               st_next.rd_data[cmdf_pkg::STAT_SAN_LSB +: 3] = st_reg.san;
               st_next.rd_data[cmdf_pkg::STAT_LAST_LSB +: 2] =
                  st_reg.last_status;
               st_next.rd_data[cmdf_pkg::STAT_UNRES_BIT] = san_unres_exit_i;
            end
            cmdf_pkg::REG_ABORTS_OFS: begin
               st_next.rd_data[15:0] = st_reg.aborts;
            end
            default: begin
               st_next.rd_data = 32'h0000_0000;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
         st_reg <= '0;
         st_reg.san <= cmdf_pkg::SAN_IDLE;
         st_reg.ctrl <= cmdf_pkg::CTRL_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   assign reg_rdata_o = st_reg.rd_data;
   assign rsp_valid_o = st_reg.rsp_valid;
   assign rsp_abort_o = st_reg.rsp_abort;
   assign rsp_status_o = st_reg.rsp_status;
   assign rsp_cid_o = st_reg.rsp_cid;
   assign rsp_stream_valid_o = st_reg.rsp_str_valid;
   assign rsp_stream_id_o = st_reg.rsp_str_id;
   assign rsp_zero_lba_o = st_reg.rsp_zero_lba;
   assign san_state_o = st_reg.san;
   // directives advertised in the support field
   always_comb begin
      optional_admin_support_field_o = '0;
      optional_admin_support_field_o[cmdf_pkg::OPTIONAL_ADMIN_SUPPORT_FIELD_DIR_BIT] = dir_sup;
   end

   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (srst_i);

   chk_io_abort_prog: assert property (
      cmd_valid_i && cmd_is_io_i && (st_reg.san == cmdf_pkg::SAN_PROG)
      |=> rsp_valid_o && rsp_abort_o &&
      (rsp_status_o == cmdf_pkg::ST_SAN_PROG))
      else $error("io command not aborted while sanitizing");
   chk_io_abort_fail: assert property (
      cmd_valid_i && cmd_is_io_i && (st_reg.san == cmdf_pkg::SAN_FAIL)
      |=> rsp_abort_o && (rsp_status_o == cmdf_pkg::ST_SAN_FAIL))
      else $error("io command not aborted in failed state");
   chk_unlisted_prog: assert property (
      cmd_valid_i && !cmd_is_io_i && (st_reg.san == cmdf_pkg::SAN_PROG) &&
      (cmd_opcode_i == cmdf_pkg::OPC_SANITIZE)
      |=> rsp_abort_o && (rsp_status_o == cmdf_pkg::ST_SAN_PROG))
      else $error("sanitize accepted while sanitizing");
   chk_san_fail_ok: assert property (
      cmd_valid_i && !cmd_is_io_i && (st_reg.san == cmdf_pkg::SAN_FAIL) &&
      (cmd_opcode_i == cmdf_pkg::OPC_SANITIZE) &&
      (cmd_san_act_i == cmdf_pkg::SACT_EXIT_FAIL)
      |=> rsp_abort_o == !$past(san_unres_exit_i))
      else $error("exit action verdict wrong in failed state");
   chk_plain_list: assert property (
      cmd_valid_i && !cmd_is_io_i && restricted &&
      is_plain_admin(cmd_opcode_i) |=> rsp_valid_o && !rsp_abort_o)
      else $error("listed admin command aborted");
   chk_log_gate: assert property (
      cmd_valid_i && !cmd_is_io_i && restricted &&
      (cmd_opcode_i == cmdf_pkg::OPC_GET_LOG)
      |=> rsp_abort_o == !is_log_ok($past(cmd_log_id_i)))
      else $error("log page gating wrong");
   chk_zero_lba: assert property (
      rsp_valid_o && rsp_zero_lba_o |-> !rsp_abort_o &&
      $past(restricted) && ($past(cmd_log_id_i) == cmdf_pkg::LID_ERROR))
      else $error("lba zeroing outside error log read");
   chk_mi_gate: assert property (
      cmd_valid_i && !cmd_is_io_i && restricted && !mi_permit_i &&
      (cmd_opcode_i == cmdf_pkg::OPC_MI_SEND) |=> rsp_abort_o)
      else $error("management send not aborted");
   chk_dir_invalid: assert property (
      cmd_valid_i && !cmd_is_io_i && !restricted && !str_ok &&
      (cmd_opcode_i == cmdf_pkg::OPC_DIR_SEND) &&
      (directive_type_field_i == cmdf_pkg::DIRECTIVE_TYPE_FIELD_STREAMS)
      |=> rsp_abort_o && (rsp_status_o == cmdf_pkg::ST_INV_FIELD))
      else $error("disabled directive type not aborted");
   chk_io_ignore: assert property (
      cmd_valid_i && cmd_is_io_i && !restricted && !str_ok
      |=> !rsp_abort_o && !rsp_stream_valid_o)
      else $error("directive fields not ignored");
   chk_stream_zero: assert property (
      cmd_valid_i && cmd_is_io_i && !restricted && str_ok &&
      (cmd_opcode_i == cmdf_pkg::OPC_IO_WRITE) &&
      (io_directive_type_field == cmdf_pkg::DIRECTIVE_TYPE_FIELD_STREAMS) &&
      (directive_specific_field_i == cmdf_pkg::DIRECTIVE_SPECIFIC_FIELD_NONE)
      |=> !rsp_abort_o && !rsp_stream_valid_o && (rsp_stream_id_o == 16'h0))
      else $error("zero stream id not a plain write");
   chk_fail_exit: assert property (
      (st_reg.san == cmdf_pkg::SAN_FAIL) && san_exit_i && !san_start_i
      |=> (st_reg.san == cmdf_pkg::SAN_IDLE) [*1])
      else $error("failed state not left on exit");
   chk_gate_order: assert property (
      cmd_valid_i && restricted |=> rsp_status_o != cmdf_pkg::ST_INV_FIELD)
      else $error("invalid field reported in restricted state");

   cov_stream_write: cover property (
      rsp_valid_o && rsp_stream_valid_o);
   cov_fail_recover: cover property (
      (st_reg.san == cmdf_pkg::SAN_FAIL) ##1
      (st_reg.san == cmdf_pkg::SAN_IDLE));
   cov_zero_lba: cover property (rsp_zero_lba_o);
   cov_inv_field: cover property (
      rsp_valid_o && (rsp_status_o == cmdf_pkg::ST_INV_FIELD));

endmodule : cmdf_filter

// ### dv/cmdf_host.sv
// Purpose: host model that submits fetched admin and io commands
// Assumes: one command per call, fields held for the taking edge only
// Notes: released fields show inverted values so stale data is never trusted
`timescale 1ns/1ps
module cmdf_host (
   input wire logic clk_i,
   output logic valid_o,
   output logic io_o,
   output logic [15:0] cid_o,
   output logic [7:0] op_o,
   output logic [7:0] lid_o,
   output logic [7:0] fct_o,
   output logic [2:0] act_o,
   output logic ud_o,
   output logic [7:0] dt_o,
   output logic [15:0] ds_o
);
   // idle lines at time zero
   initial begin
      {valid_o, io_o, cid_o, op_o, lid_o, fct_o, act_o, ud_o, dt_o, ds_o} = '0;
   end
   // one command: drive after an edge, hold through the taking edge
   task send(input logic io, input logic [7:0] op, input logic [7:0] lid,
             input logic [7:0] fct, input logic [2:0] act, input logic ud,
             input logic [7:0] dt, input logic [15:0] ds);
      @(posedge clk_i);
      valid_o <= 1'b1;
      {io_o, op_o, lid_o, fct_o, act_o, ud_o, dt_o, ds_o} <=
         {io, op, lid, fct, act, ud, dt, ds};
      cid_o <= {8'ha5, op};
      @(posedge clk_i);
      valid_o <= 1'b0;
      {io_o, cid_o, op_o, lid_o, fct_o, act_o, ud_o, dt_o, ds_o} <=
         ~{io_o, cid_o, op_o, lid_o, fct_o, act_o, ud_o, dt_o, ds_o};
   endtask : send
endmodule : cmdf_host

// ### dv/cmdf_filter_tb_top.sv
// Purpose: self-checking bench of the command admission filter
// Assumes: host model sends commands, bench drives registers and events
// Notes: every verdict is judged one cycle after its command
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module cmdf_filter_tb_top;
   localparam logic [1:0] OK = cmdf_pkg::ST_OK;
   localparam logic [1:0] SP = cmdf_pkg::ST_SAN_PROG;
   localparam logic [1:0] SF = cmdf_pkg::ST_SAN_FAIL;
   localparam logic [1:0] IV = cmdf_pkg::ST_INV_FIELD;
   logic sys_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] sev = 4'h0; // start, pass, fail, exit pulses
   logic unres = 1'b0;
   logic mi_ok = 1'b0;
   logic [31:0] rdata;
   logic c_val, c_io, c_ud, r_val, r_ab, r_sv, r_zl;
   logic [15:0] c_cid, c_ds, r_cid, r_sid, optional_admin_support_field;
   logic [7:0] c_op, c_lid, c_fct, c_dt;
   logic [2:0] c_act, san;
   logic [1:0] r_st;
   int fail_count = 0;
   int tests_run = 0;
   int cycles = 0;
   // clock of 100 ns
   always #50 sys_clk_i = ~sys_clk_i;
   cmdf_host host (.clk_i(sys_clk_i), .valid_o(c_val), .io_o(c_io),
      .cid_o(c_cid), .op_o(c_op), .lid_o(c_lid), .fct_o(c_fct),
      .act_o(c_act), .ud_o(c_ud), .dt_o(c_dt), .ds_o(c_ds));
   cmdf_filter uut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .san_start_i(sev[0]),
      .san_pass_i(sev[1]), .san_fail_i(sev[2]), .san_exit_i(sev[3]),
      .san_unres_exit_i(unres), .mi_permit_i(mi_ok), .cmd_valid_i(c_val),
      .cmd_is_io_i(c_io), .cmd_cid_i(c_cid), .cmd_opcode_i(c_op),
      .cmd_log_id_i(c_lid), .cmd_fctype_i(c_fct), .cmd_san_act_i(c_act),
      .cmd_user_data_i(c_ud), .directive_type_field_i(c_dt),
      .directive_specific_field_i(c_ds), .rsp_valid_o(r_val),
      .rsp_abort_o(r_ab), .rsp_status_o(r_st), .rsp_cid_o(r_cid),
      .rsp_stream_valid_o(r_sv), .rsp_stream_id_o(r_sid),
      .rsp_zero_lba_o(r_zl), .optional_admin_support_field_o(optional_admin_support_field),
      .san_state_o(san));
   // verdict one cycle after the command
   task chk(input logic ab, input logic [1:0] st);
      #1;
      `CHK(r_val, 1'b1)
      `CHK(r_ab, ab)
      `CHK(r_st, st)
      `CHK(r_cid[15:8], 8'ha5)
   endtask : chk
   task wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk_i);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk_i);
      reg_rd <= 1'b0;
      #1;
      `CHK(rdata, e)
   endtask : rd
   task ev(input int i, input logic [2:0] e);
      @(posedge sys_clk_i);
      sev[i] <= 1'b1;
      @(posedge sys_clk_i);
      sev <= 4'h0;
      #1;
      `CHK(san, e)
   endtask : ev
   // reset values, directives off means io fields ignored
   task t_reset;
      #1;
      `CHK(san, 3'b001)
      `CHK(optional_admin_support_field, 16'h0000)
      rd(8'h00, 32'h0);
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h02, 16'h0007);
      chk(0, OK);
   endtask : t_reset
   // directive decode with streams disabled, then enabled
   task t_dir;
      wr(8'h00, 32'h3);
      `CHK(optional_admin_support_field, 16'h0020)
      host.send(0, 8'h19, 0, 0, 0, 0, 8'h01, 16'h0);
      chk(1, IV);
      wr(8'h00, 32'h7);
      rd(8'h00, 32'h7);
      rd(8'h0c, 32'h0);
      host.send(0, 8'h1a, 0, 0, 0, 0, 8'h00, 16'h0);
      chk(0, OK);
      host.send(0, 8'h19, 0, 0, 0, 0, 8'h01, 16'h0);
      chk(0, OK);
      host.send(0, 8'h19, 0, 0, 0, 0, 8'h02, 16'h0);
      chk(1, IV);
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h01, 16'h0005);
      chk(0, OK);
      `CHK({r_sv, r_sid}, {1'b1, 16'h0005})
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h01, 16'h0000);
      chk(0, OK);
      `CHK(r_sv, 1'b0)
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h10, 16'h0005);
      chk(0, OK);
      `CHK(r_sv, 1'b0)
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h11, 16'h0009);
      chk(0, OK);
      `CHK(r_sid, 16'h0009)
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h02, 16'h0);
      chk(1, IV);
      host.send(1, 8'h02, 0, 0, 0, 0, 8'h02, 16'h0);
      chk(0, OK);
   endtask : t_dir
   // sanitize in progress gating
   task t_prog;
      logic [7:0] ops[10] = '{8'h08, 8'h0c, 8'h05, 8'h01, 8'h04, 8'h00,
                              8'h0a, 8'h06, 8'h18, 8'h09};
      ev(0, 3'b010);
      host.send(1, 8'h01, 0, 0, 0, 0, 8'h02, 16'h0);
      chk(1, SP);
      for (int i = 0; i < 10; i++) begin
         host.send(0, ops[i], 0, 0, 0, 0, 0, 0);
         chk(0, OK);
      end
      host.send(0, 8'h02, 8'h03, 0, 0, 0, 0, 0);
      chk(1, SP);
      host.send(0, 8'h02, 8'h01, 0, 0, 0, 0, 0);
      chk(0, OK);
      `CHK(r_zl, 1'b1)
      host.send(0, 8'h1d, 0, 0, 0, 0, 0, 0);
      chk(1, SP);
      @(posedge sys_clk_i);
      mi_ok <= 1'b1;
      host.send(0, 8'h1e, 0, 0, 0, 0, 0, 0);
      chk(0, OK);
      host.send(0, 8'h7f, 0, 8'h01, 0, 0, 0, 0);
      chk(0, OK);
      host.send(0, 8'hc0, 0, 0, 0, 1, 0, 0);
      chk(1, SP);
      host.send(0, 8'h84, 0, 0, 3'h2, 0, 0, 0);
      chk(1, SP);
      host.send(0, 8'h19, 0, 0, 0, 0, 8'h05, 0);
      chk(1, SP);
      ev(2, 3'b100);
   endtask : t_prog
   // sanitize failed state and recovery
   task t_fail;
      host.send(1, 8'h01, 0, 0, 0, 0, 0, 0);
      chk(1, SF);
      host.send(0, 8'h19, 0, 0, 0, 0, 0, 0);
      chk(1, SF);
      host.send(0, 8'h84, 0, 0, 3'h2, 0, 0, 0);
      chk(0, OK);
      host.send(0, 8'h84, 0, 0, 3'h1, 0, 0, 0);
      chk(1, SF);
      rd(8'h04, 32'h24);
      @(posedge sys_clk_i);
      unres <= 1'b1;
      host.send(0, 8'h84, 0, 0, 3'h1, 0, 0, 0);
      chk(0, OK);
      rd(8'h04, 32'h104);
      rd(8'h08, 32'hc);
      wr(8'h08, 32'h0);
      rd(8'h08, 32'h0);
      ev(3, 3'b001);
      host.send(1, 8'h01, 0, 0, 0, 0, 0, 0);
      chk(0, OK);
      ev(0, 3'b010);
      ev(1, 3'b001);
   endtask : t_fail
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : end_sim
   // hang guard
   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         end_sim();
      end
   end
   initial begin
      repeat (6) @(posedge sys_clk_i);
      srst_i <= 1'b0;
      t_reset();
      t_dir();
      t_prog();
      t_fail();
      end_sim();
   end
endmodule : cmdf_filter_tb_top
